/* rtl/sac_map.svh */
// register map, field positions and reset values of the switch and check register bank
// assumes: 7-bit register address carried in each serial command
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ==========================================================
// addresses
`define SAC_ADDR_SW 7'h01
`define SAC_ADDR_CFG 7'h02
`define SAC_ADDR_FLAGS 7'h03
`define SAC_ADDR_BURST 7'h05
`define SAC_ADDR_SRST 7'h0B

// ==========================================================
// reset values
`define SAC_SW_RST 4'h0
`define SAC_CFG_RST 3'h6

// ==========================================================
// field positions
`define SAC_SW_MSB 3
`define SAC_CFG_RW_BIT 2
`define SAC_CFG_SCLK_BIT 1
`define SAC_CFG_CRC_BIT 0

// ==========================================================
// serial clock counts per command
`define SAC_SCLK_PLAIN 16
`define SAC_SCLK_CRC 24

`endif

/* rtl/sac_mult_chk.sv */
// tells whether a frame's serial clock count fits a command length
// assumes: count sampled on the frame's end pulse, same clock as caller
`timescale 1ns/10ps
module sac_mult_chk #(
	parameter int CNT_W = 16,
	parameter int UNIT = 16
) (
	// frame count
	input wire logic [CNT_W-1:0] count,
	// verdicts
	output logic isExact,
	output logic isMultiple
);
	localparam logic [CNT_W-1:0] UNIT_C = CNT_W'(UNIT);

	// ==========================================================
	// exact length and whole multiple, zero never counts as a frame
	always_comb begin
		isExact = (count == UNIT_C);
		isMultiple = (count != '0) && ((count % UNIT_C) == '0);
	end
endmodule

/* rtl/sac_pkg.sv */
// types shared by the switch and check register bank
// assumes: sac_map.svh supplies the numbers
package sac_pkg;
	// one register command handed over by the serial frame engine
	typedef struct packed {
		logic write; // 1 write, 0 read
		logic [6:0] addr; // register address
		logic [7:0] data; // write data
	} sac_cmd_type;

	// the three check enables, msb first as in the register
	typedef struct packed {
		logic rwEn; // invalid address check
		logic sclkEn; // clock count check
		logic crcEn; // checksum check, 24-bit frames
	} sac_cfg_type;
endpackage

/* rtl/sac_regs.sv */
// switch state and error check configuration registers
// assumes: a serial frame engine on mclk decodes commands and counts clocks
// Operation
// - switch bits close switches one to four
// - upper unused bits read zero, ignore writes
// - switch state at one, resets open
// - check config at two, resets to 0x06
// - bit two enables invalid address check
// - bit one enables clock count check
// - plain single frames need exactly 16 clocks
// - checksum single frames need exactly 24 clocks
// - plain burst frames need multiples of 16
// - checksum burst frames need multiples of 24
// - bit zero enables checksum, 24-bit frames
// - writing a read-only register flags invalid address
// - chained mode sends every command to switches
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_regs #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// command from the frame engine
	input wire logic cmdValid,
	input wire sac_pkg::sac_cmd_type cmd,
	// mode levels and resets kept by the engine
	input wire logic burstMode,
	input wire logic chainMode,
	input wire logic softReset,
	// end of a chip-select frame with its clock count
	input wire logic frameEnd,
	input wire logic [CNT_W-1:0] frameClocks,
	// switch drive
	output logic [3:0] switchClose,
	// check enables and frame length
	output sac_pkg::sac_cfg_type checkEn,
	output logic [4:0] frameBits,
	// read answer
	output logic [7:0] rdData,
	output logic rdValid,
	// events
	output logic swWrite,
	output logic cfgWrite,
	output logic rwAddrErr,
	output logic sclkCountErr
);
	// ==========================================================
	// storage, only implemented bits exist
	logic [3:0] swState_reg; // switch closures
	sac_pkg::sac_cfg_type cfg_reg; // check enables
	logic [4:0] frameBits_reg; // current frame length
	logic [7:0] rdData_reg; // read answer
	logic rdValid_reg; // read answer valid
	logic swWrite_reg; // switch state written
	logic cfgWrite_reg; // configuration written
	logic rwErr_reg; // invalid address event
	logic sclkErr_reg; // clock count event

	// decode of the current command
	logic wrSw; // write lands in switch state
	logic wrCfg; // write lands in configuration
	logic badAddr; // nonexistent or read-only target
	logic exact16;
	logic mult16;
	logic exact24;
	logic mult24;
	logic countOk;

	// ==========================================================
	// command decode
	always_comb begin
		// chained mode has no address, so everything hits the switches
		wrSw = cmdValid && (chainMode || (cmd.write && cmd.addr == `SAC_ADDR_SW));
		wrCfg = cmdValid && !chainMode && cmd.write && cmd.addr == `SAC_ADDR_CFG;
		badAddr = 1'b0;
		if (cmdValid && !chainMode) begin
			unique case (cmd.addr)
				`SAC_ADDR_SW, `SAC_ADDR_CFG, `SAC_ADDR_BURST, `SAC_ADDR_SRST: begin
					badAddr = 1'b0;
				end
				// flags register may be read but never written
				`SAC_ADDR_FLAGS: begin
					badAddr = cmd.write;
				end
				default: begin
					badAddr = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// clock count judges, one per command length
	sac_mult_chk #(.CNT_W(CNT_W), .UNIT(`SAC_SCLK_PLAIN)) u_chk16 (
		.count(frameClocks),
		.isExact(exact16),
		.isMultiple(mult16)
	);
	sac_mult_chk #(.CNT_W(CNT_W), .UNIT(`SAC_SCLK_CRC)) u_chk24 (
		.count(frameClocks),
		.isExact(exact24),
		.isMultiple(mult24)
	);

	// pick the expectation from checksum and burst settings
	always_comb begin
		unique case ({cfg_reg.crcEn, burstMode})
			2'b00: countOk = exact16;
			2'b10: countOk = exact24;
			2'b01: countOk = mult16;
			2'b11: countOk = mult24;
		endcase
	end

	// ==========================================================
	// switch state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			swState_reg <= `SAC_SW_RST;
		end else if (softReset) begin
			swState_reg <= `SAC_SW_RST;
		end else if (wrSw) begin
			// upper data bits are dropped, they have no storage
			swState_reg <= cmd.data[`SAC_SW_MSB:0];
		end
	end

	// ==========================================================
	// check configuration register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg <= `SAC_CFG_RST;
		end else if (softReset) begin
			cfg_reg <= `SAC_CFG_RST;
		end else if (wrCfg) begin
			cfg_reg.rwEn <= cmd.data[`SAC_CFG_RW_BIT];
			cfg_reg.sclkEn <= cmd.data[`SAC_CFG_SCLK_BIT];
			cfg_reg.crcEn <= cmd.data[`SAC_CFG_CRC_BIT];
		end
	end

	// frame length follows the checksum enable, registered for the engine
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frameBits_reg <= 5'(`SAC_SCLK_PLAIN);
		end else begin
			frameBits_reg <= cfg_reg.crcEn ? 5'(`SAC_SCLK_CRC) : 5'(`SAC_SCLK_PLAIN);
		end
	end

	// ==========================================================
	// read answer, unused bits always zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_reg <= 8'h00;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= cmdValid && !chainMode && !cmd.write;
			if (cmd.addr == `SAC_ADDR_SW) begin
				rdData_reg <= {4'h0, swState_reg};
			end else if (cmd.addr == `SAC_ADDR_CFG) begin
				rdData_reg <= {5'h00, cfg_reg};
			end else begin
				// other registers are merged in by the engine
				rdData_reg <= 8'h00;
			end
		end
	end

	// ==========================================================
	// events: write strobes and gated error pulses
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			swWrite_reg <= 1'b0;
			cfgWrite_reg <= 1'b0;
			rwErr_reg <= 1'b0;
			sclkErr_reg <= 1'b0;
		end else begin
			swWrite_reg <= wrSw && !softReset;
			cfgWrite_reg <= wrCfg && !softReset;
			// a disabled check stays silent whatever arrives
			rwErr_reg <= badAddr && cfg_reg.rwEn;
			sclkErr_reg <= frameEnd && cfg_reg.sclkEn && !countOk;
		end
	end

	// outputs straight from flops
	assign switchClose = swState_reg;
	assign checkEn = cfg_reg;
	assign frameBits = frameBits_reg;
	assign rdData = rdData_reg;
	assign rdValid = rdValid_reg;
	assign swWrite = swWrite_reg;
	assign cfgWrite = cfgWrite_reg;
	assign rwAddrErr = rwErr_reg;
	assign sclkCountErr = sclkErr_reg;

	// ==========================================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_sw_write: assert property (
		cmdValid && cmd.write && cmd.addr == `SAC_ADDR_SW && !chainMode && !softReset
		|=> switchClose == $past(cmd.data[3:0]) && swWrite)
		else $error("switch state did not take written data");
	chk_sw_upper_zero: assert property (
		rdValid && $past(cmd.addr) == `SAC_ADDR_SW |-> rdData[7:4] == 4'h0)
		else $error("switch state upper bits not zero");
	chk_sw_soft_reset: assert property (
		softReset |=> switchClose == 4'h0 ##1 switchClose == 4'h0 || $past(wrSw))
		else $error("switches not opened by reset");
	chk_cfg_soft_reset: assert property (
		softReset |=> checkEn == 3'h6)
		else $error("configuration not restored to default");
	chk_ro_write_err: assert property (
		cmdValid && cmd.write && cmd.addr == `SAC_ADDR_FLAGS && !chainMode && checkEn.rwEn
		|=> rwAddrErr ##1 !rwAddrErr || $past(badAddr))
		else $error("read-only write not flagged");
	chk_chain_cfg_hold: assert property (
		cmdValid && chainMode && !softReset |=> $stable(checkEn) && swWrite)
		else $error("chained command changed configuration");
	chk_rw_disabled: assert property (
		!checkEn.rwEn |=> !rwAddrErr)
		else $error("disabled address check flagged");
	chk_sclk_disabled: assert property (
		!checkEn.sclkEn |=> !sclkCountErr)
		else $error("disabled count check flagged");
	chk_sclk_plain: assert property (
		frameEnd && checkEn.sclkEn && !checkEn.crcEn && !burstMode
		|=> sclkCountErr == ($past(frameClocks) != CNT_W'(`SAC_SCLK_PLAIN)))
		else $error("single plain frame count misjudged");
	chk_sclk_crc: assert property (
		frameEnd && checkEn.sclkEn && checkEn.crcEn && !burstMode
		|=> sclkCountErr == ($past(frameClocks) != CNT_W'(`SAC_SCLK_CRC)))
		else $error("single checksum frame count misjudged");
	chk_burst_plain: assert property (
		frameEnd && checkEn.sclkEn && !checkEn.crcEn && burstMode && frameClocks == CNT_W'(48)
		|=> !sclkCountErr)
		else $error("plain burst of three commands refused");
	chk_burst_crc: assert property (
		frameEnd && checkEn.sclkEn && checkEn.crcEn && burstMode && frameClocks == CNT_W'(32)
		|=> sclkCountErr)
		else $error("checksum burst of 32 clocks accepted");
	chk_frame_bits: assert property (
		$rose(checkEn.crcEn) |=> frameBits == 5'(`SAC_SCLK_CRC))
		else $error("frame length not widened");

	cov_sw_write: cover property (swWrite ##1 switchClose != 4'h0);
	cov_cfg_write: cover property (cfgWrite && !checkEn.rwEn);
	cov_sclk_err: cover property (burstMode && sclkCountErr);
	cov_chain: cover property (chainMode && swWrite);
endmodule

/* verif/sac_host_model.sv */
// frame engine stand-in: hands commands and frame ends to the bank
// assumes: one request at a time, launched on rising mclk
`timescale 1ns/10ps
module sac_host_model (
	// clock
	input wire logic mclk,
	// command and frame end toward the bank
	output sac_pkg::sac_cmd_type cmd,
	output logic cmdValid,
	output logic frameEnd,
	output logic [15:0] frameClocks
);
	// ====
	// idle: all fields start at zero, then each task inverts stale fields so nothing reads old data by luck
	initial begin
		cmd = 16'h0000;
		cmdValid = 1'b0;
		frameEnd = 1'b0;
		frameClocks = 16'h0000;
	end
	// one command, held for exactly the taking edge
	task automatic send_cmd(input logic [15:0] c);
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmd <= c;
		@(posedge mclk);
		cmdValid <= 1'b0;
		cmd <= ~c;
		#1;
	endtask
	// frame end carrying the clocks counted while selected
	task automatic send_frame(input logic [15:0] n);
		@(posedge mclk);
		frameEnd <= 1'b1;
		frameClocks <= n;
		@(posedge mclk);
		frameEnd <= 1'b0;
		frameClocks <= ~n;
		#1;
	endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the switch and check register bank
// assumes: host model drives commands, bench drives mode levels
`timescale 1ns/10ps
module tb;
	// ====
	// clock, reset, mode levels
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic burstMode = 1'b0;
	logic chainMode = 1'b0;
	logic softReset = 1'b0;
	sac_pkg::sac_cmd_type cmd;
	logic cmdValid, frameEnd;
	logic [15:0] frameClocks;
	logic [3:0] switchClose;
	sac_pkg::sac_cfg_type checkEn;
	logic [4:0] frameBits;
	logic [7:0] rdData;
	logic rdValid, swWrite, cfgWrite, rwAddrErr, sclkCountErr;
	int n_mismatch = 0;
	int compares = 0;
	// row: command, switches, enables, read valid, read data, address error
	typedef struct packed {
		logic [15:0] c;
		logic [3:0] sw;
		logic [2:0] cfg;
		logic rv;
		logic [7:0] rd;
		logic er;
	} sac_row_type;
	// upper bits written as ones on purpose, they must drop
	sac_row_type rows [10] = '{
		'{16'h81FF, 4'hF, 3'h6, 1'b0, 8'h00, 1'b0}, '{16'h0100, 4'hF, 3'h6, 1'b1, 8'h0F, 1'b0},
		'{16'h8105, 4'h5, 3'h6, 1'b0, 8'h00, 1'b0}, '{16'h82FF, 4'h5, 3'h7, 1'b0, 8'h00, 1'b0},
		'{16'h0200, 4'h5, 3'h7, 1'b1, 8'h07, 1'b0}, '{16'h8300, 4'h5, 3'h7, 1'b0, 8'h00, 1'b1},
		'{16'hFF00, 4'h5, 3'h7, 1'b0, 8'h00, 1'b1}, '{16'h8203, 4'h5, 3'h3, 1'b0, 8'h00, 1'b0},
		'{16'hFF00, 4'h5, 3'h3, 1'b0, 8'h00, 1'b0}, '{16'h8206, 4'h5, 3'h6, 1'b0, 8'h00, 1'b0}};

	always #5 mclk = ~mclk;

	// ====
	// design and far side
	sac_regs dut_u (.mclk(mclk), .arst_n(arst_n), .cmdValid(cmdValid), .cmd(cmd),
		.burstMode(burstMode), .chainMode(chainMode), .softReset(softReset),
		.frameEnd(frameEnd), .frameClocks(frameClocks), .switchClose(switchClose),
		.checkEn(checkEn), .frameBits(frameBits), .rdData(rdData), .rdValid(rdValid),
		.swWrite(swWrite), .cfgWrite(cfgWrite), .rwAddrErr(rwAddrErr),
		.sclkCountErr(sclkCountErr));
	sac_host_model host_u (.mclk(mclk), .cmd(cmd), .cmdValid(cmdValid),
		.frameEnd(frameEnd), .frameClocks(frameClocks));

	// ====
	// compare, verdict, watchdog
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// under a hundred cycles expected, so 10000 means a hang
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
	// one frame end with a burst setting, error expected or not
	task automatic frm(input logic b, input logic [15:0] n, input logic e);
		@(posedge mclk);
		burstMode <= b;
		host_u.send_frame(n);
		check("sclkCountErr", sclkCountErr, e);
	endtask

	// ====
	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		check("switchClose", switchClose, 4'h0);
		check("checkEn", checkEn, 3'h6);
		check("frameBits", frameBits, 5'h10);
		foreach (rows[i]) begin
			host_u.send_cmd(rows[i].c);
			check("switchClose", switchClose, rows[i].sw);
			check("checkEn", checkEn, rows[i].cfg);
			check("rdValid", rdValid, rows[i].rv);
			if (rows[i].rv) check("rdData", rdData, rows[i].rd);
			check("rwAddrErr", rwAddrErr, rows[i].er);
			check("swWrite", swWrite, rows[i].c[15:8] == 8'h81);
			check("cfgWrite", cfgWrite, rows[i].c[15:8] == 8'h82);
		end
		// single and burst counts, checksum off
		frm(1'b0, 16'h0010, 1'b0);
		frm(1'b0, 16'h0011, 1'b1);
		frm(1'b0, 16'h0000, 1'b1);
		frm(1'b1, 16'h0020, 1'b0);
		frm(1'b1, 16'h0018, 1'b1);
		frm(1'b1, 16'h0030, 1'b0);
		// checksum on widens frames
		host_u.send_cmd(16'h8207);
		frm(1'b0, 16'h0018, 1'b0);
		check("frameBits", frameBits, 5'h18);
		frm(1'b0, 16'h0010, 1'b1);
		frm(1'b1, 16'h0030, 1'b0);
		frm(1'b1, 16'h0020, 1'b1);
		// clock count check off: a bad count passes quietly
		host_u.send_cmd(16'h8205);
		frm(1'b0, 16'h0011, 1'b0);
		// soft reset beats a write in the same cycle
		fork
			host_u.send_cmd(16'h810F);
			begin
				@(posedge mclk);
				softReset <= 1'b1;
				@(posedge mclk);
				softReset <= 1'b0;
			end
		join
		check("switchClose", switchClose, 4'h0);
		check("checkEn", checkEn, 3'h6);
		check("swWrite", swWrite, 1'b0);
		// chained mode: every command lands on the switches
		@(posedge mclk);
		chainMode <= 1'b1;
		host_u.send_cmd(16'h820A);
		check("switchClose", switchClose, 4'hA);
		check("checkEn", checkEn, 3'h6);
		check("cfgWrite", cfgWrite, 1'b0);
		host_u.send_cmd(16'hFF03);
		check("rwAddrErr", rwAddrErr, 1'b0);
		// hardware reset in mid-run
		@(posedge mclk);
		arst_n <= 1'b0;
		chainMode <= 1'b0;
		#1;
		check("switchClose", switchClose, 4'h0);
		check("checkEn", checkEn, 3'h6);
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		// defaults still stand after release, and the first read is answered
		check("frameBits", frameBits, 5'h10);
		check("rdValid", rdValid, 1'b0);
		check("switchClose", switchClose, 4'h0);
		host_u.send_cmd(16'h0200);
		check("rdValid", rdValid, 1'b1);
		check("rdData", rdData, 8'h06);
		final_report();
	end
endmodule
